// *** rtl/event_interval_timer_map.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef EVENT_INTERVAL_TIMER_MAP_SVH
`define EVENT_INTERVAL_TIMER_MAP_SVH

`define EIT_CLK_HZ 50000000
`define EIT_MIN_SAMPLES 32'h0000_0002

`define EIT_OFS_CTRL 8'h00
`define EIT_OFS_PRI_CFG 8'h04
`define EIT_OFS_PRI_SCALE 8'h08
`define EIT_OFS_PRI_LOWER 8'h0c
`define EIT_OFS_PRI_UPPER 8'h10
`define EIT_OFS_SEC_CFG 8'h14
`define EIT_OFS_SEC_SCALE 8'h18
`define EIT_OFS_SEC_LOWER 8'h1c
`define EIT_OFS_SEC_UPPER 8'h20
`define EIT_OFS_BOUND_MIN 8'h24
`define EIT_OFS_BOUND_MAX 8'h28
`define EIT_OFS_RESULT 8'h2c
`define EIT_OFS_STATUS 8'h30
`define EIT_OFS_MEAS_COUNT 8'h34

`define EIT_CTRL_MODE_LSB 0
`define EIT_CTRL_UNIT_LSB 2
`define EIT_CTRL_OUT_LSB 4
`define EIT_CTRL_BOUND_BIT 6
`define EIT_CTRL_GATE_LSB 7
`define EIT_CTRL_MANUAL_BIT 9
`define EIT_CTRL_TAU_LSB 10
`define EIT_CTRL_WIDTH 15

`define EIT_CTRL_RESET 15'h0000
`define EIT_CFG_RESET 3'h0
`define EIT_SCALE_RESET 32'h0001_0000
`define EIT_WORD_RESET 32'h0000_0000

`endif

// *** rtl/event_interval_timer_pkg.sv ***
// types shared by the event interval timer
package event_interval_timer_pkg;
	typedef enum logic [1:0] {MEAS_PERIOD, MEAS_FREQ, MEAS_DURATION,
		MEAS_BETWEEN} meas_mode_type;
	typedef enum logic [1:0] {OUT_LATCH, OUT_SMOOTH, OUT_LIVE,
		OUT_SPARE} out_mode_type;
	typedef enum logic [1:0] {GATE_NONE, GATE_INPUT, GATE_MANUAL,
		GATE_SPARE} gate_type;
	typedef enum logic [2:0] {TEST_TRUE, TEST_FALSE, TEST_ABOVE, TEST_BELOW,
		TEST_INSIDE, TEST_OUTSIDE, TEST_SPARE6, TEST_SPARE7} test_type;
endpackage

// *** rtl/truth_test.sv ***
// scaled threshold truth test for one input
`timescale 1ns/1ps
module truth_test (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// input sample
	input wire logic [31:0] i_sample,
	input wire logic i_logic,
	// configuration
	input wire logic [2:0] i_test,
	input wire logic [31:0] i_scale,
	input wire logic [31:0] i_lower_threshold,
	input wire logic [31:0] i_upper_threshold,
	// result
	output logic o_truth
);
	logic signed [63:0] product;
	logic signed [31:0] scaled;
	logic above_lo;
	logic below_lo;
	logic in_range;
	logic truth_next;

	// scale is signed q16.16
	assign product = $signed(i_sample) * $signed(i_scale);
	assign scaled = product[47:16];
	assign above_lo = scaled > $signed(i_lower_threshold);
	assign below_lo = scaled < $signed(i_lower_threshold);
	assign in_range = (scaled >= $signed(i_lower_threshold)) &&
		(scaled <= $signed(i_upper_threshold));

	always_comb begin
		unique case (event_interval_timer_pkg::test_type'(i_test))
			event_interval_timer_pkg::TEST_TRUE: truth_next = i_logic;
			event_interval_timer_pkg::TEST_FALSE: truth_next = !i_logic;
			event_interval_timer_pkg::TEST_ABOVE: truth_next = above_lo;
			event_interval_timer_pkg::TEST_BELOW: truth_next = below_lo;
			event_interval_timer_pkg::TEST_INSIDE: truth_next = in_range;
			event_interval_timer_pkg::TEST_OUTSIDE: truth_next = !in_range;
			default: truth_next = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_truth <= 1'b0;
		end else begin
			o_truth <= truth_next;
		end
	end
endmodule // truth_test

// *** rtl/event_interval_timer.sv ***
// event interval timer with apb registers
// Function
// - numeric input is scaled, then threshold-tested; logic input tests true or false
// - above and below tests compare only against the lower threshold
// - inside and outside tests use lower as minimum, upper as maximum
// - no measurement shorter than two clock samples is reported
// - period mode measures time between successive primary onsets
// - frequency mode reports onset rate in hz, khz or bpm
// - duration mode measures primary onset to following primary offset
// - between mode measures primary onset to next secondary onset
// - a zero bound limit means that side is unbounded
// - bounded period or frequency clamps to the nearer limit
// - bounded duration outside limits is discarded without valid pulse
// - bounded between mode ignores primary onsets while below minimum
// - bounded between mode ignores secondary onsets outside the limits
// - latch mode loads result on measurement and holds it
// - smoothed mode latches through an exponential filter of set tau
// - live period result restarts at zero on onset and ramps
// - live period result holds at maximum bound once reached
// - live period result holds at minimum bound until minimum time
// - live frequency decays once elapsed time implies lower rate
// - live duration ramps from zero until offset or maximum, then holds
// - live between ramps from zero until secondary or maximum, then holds
// - gate is always on, external enable input, or manual control bit
// - valid is a one-cycle pulse coincident with the updated result
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "event_interval_timer_map.svh"
module event_interval_timer #(
	parameter int CLK_HZ = `EIT_CLK_HZ,
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// sample inputs
	input wire logic [31:0] i_pri_sample,
	input wire logic i_pri_logic,
	input wire logic [31:0] i_sec_sample,
	input wire logic i_sec_logic,
	input wire logic i_gate_enable,
	// measurement outputs
	output logic [31:0] o_result,
	output logic o_valid
);
	localparam longint unsigned SC_SAMPLE = 64'h0000_0001_0000_0000;
	localparam longint unsigned SC_US = SC_SAMPLE * 1000000 / CLK_HZ;
	localparam longint unsigned SC_MS = SC_SAMPLE * 1000 / CLK_HZ;
	localparam longint unsigned SC_S = SC_SAMPLE / CLK_HZ;
	localparam longint unsigned F_HZ = 64'd65536 * CLK_HZ;
	localparam longint unsigned F_KHZ = F_HZ / 1000;
	localparam longint unsigned F_BPM = F_HZ * 60;

	if (CLK_HZ < 1000 || ADDR_W < 8) begin : g_bad_param
		$error("clock rate or address width not supported");
	end

	logic [`EIT_CTRL_WIDTH-1:0] ctrl_reg;
	logic [2:0] pri_cfg_reg, sec_cfg_reg;
	logic [31:0] pri_scale_reg, pri_lo_reg, pri_hi_reg;
	logic [31:0] sec_scale_reg, sec_lo_reg, sec_hi_reg;
	logic [31:0] bmin_reg, bmax_reg, meas_total_reg;
	logic pri_truth, sec_truth, pri_prev_reg, sec_prev_reg;
	logic run_reg, meas_evt_reg;
	logic [31:0] cnt_reg, meas_cnt_reg, last_int_reg;
	logic div_busy_reg, div_done_reg, div_meas_reg;
	logic [5:0] div_bit_reg;
	logic [47:0] div_num_reg, div_q_reg;
	logic [31:0] div_rem_reg, div_den_reg;

	event_interval_timer_pkg::meas_mode_type mode;
	event_interval_timer_pkg::out_mode_type out_mode;
	event_interval_timer_pkg::gate_type gate_sel;
	logic [1:0] unit;
	logic [4:0] tau;
	logic bounded, active, is_freq, has_max, below_min, above_max;
	logic pri_on, pri_off, sec_on, start, take, stop, run_next;
	logic [31:0] min_lim, max_lim, take_val, live_cnt;

	// bound helper: zero limit means unbounded
	function automatic logic [31:0] clamp_cnt(input logic [31:0] x,
		input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] r;
		r = x;
		if (x < lo) begin
			r = lo;
		end
		if (hi != 32'h0000_0000 && x > hi) begin
			r = hi;
		end
		return r;
	endfunction

	assign mode = event_interval_timer_pkg::meas_mode_type'(
		ctrl_reg[`EIT_CTRL_MODE_LSB +: 2]);
	assign out_mode = event_interval_timer_pkg::out_mode_type'(
		ctrl_reg[`EIT_CTRL_OUT_LSB +: 2]);
	assign gate_sel = event_interval_timer_pkg::gate_type'(
		ctrl_reg[`EIT_CTRL_GATE_LSB +: 2]);
	assign unit = ctrl_reg[`EIT_CTRL_UNIT_LSB +: 2];
	assign tau = ctrl_reg[`EIT_CTRL_TAU_LSB +: 5];
	assign bounded = ctrl_reg[`EIT_CTRL_BOUND_BIT];
	assign is_freq = mode == event_interval_timer_pkg::MEAS_FREQ;

	// gating
	assign active = (gate_sel == event_interval_timer_pkg::GATE_NONE) ||
		(gate_sel == event_interval_timer_pkg::GATE_INPUT &&
		i_gate_enable) ||
		(gate_sel == event_interval_timer_pkg::GATE_MANUAL &&
		ctrl_reg[`EIT_CTRL_MANUAL_BIT]);

	// truth tests
	truth_test u_pri_test (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_sample(i_pri_sample),
		.i_logic(i_pri_logic),
		.i_test(pri_cfg_reg),
		.i_scale(pri_scale_reg),
		.i_lower_threshold(pri_lo_reg),
		.i_upper_threshold(pri_hi_reg),
		.o_truth(pri_truth)
	);
	truth_test u_sec_test (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_sample(i_sec_sample),
		.i_logic(i_sec_logic),
		.i_test(sec_cfg_reg),
		.i_scale(sec_scale_reg),
		.i_lower_threshold(sec_lo_reg),
		.i_upper_threshold(sec_hi_reg),
		.o_truth(sec_truth)
	);

	// edges
	assign pri_on = active && pri_truth && !pri_prev_reg;
	assign pri_off = active && !pri_truth && pri_prev_reg;
	assign sec_on = active && sec_truth && !sec_prev_reg;

	// limits
	assign min_lim = bounded ? bmin_reg : 32'h0000_0000;
	assign max_lim = bounded ? bmax_reg : 32'h0000_0000;
	assign has_max = max_lim != 32'h0000_0000;
	assign below_min = cnt_reg < min_lim;
	assign above_max = has_max && cnt_reg > max_lim;
	assign take_val = clamp_cnt(cnt_reg, min_lim, max_lim);
	assign live_cnt = take_val;

	// measurement decisions per mode
	always_comb begin
		start = pri_on;
		take = 1'b0;
		stop = 1'b0;
		unique case (mode)
			event_interval_timer_pkg::MEAS_PERIOD,
			event_interval_timer_pkg::MEAS_FREQ: begin
				take = pri_on && run_reg;
			end
			event_interval_timer_pkg::MEAS_DURATION: begin
				take = pri_off && run_reg && !below_min && !above_max;
				stop = pri_off;
			end
			event_interval_timer_pkg::MEAS_BETWEEN: begin
				start = pri_on && !(run_reg && bounded && below_min);
				take = sec_on && run_reg && !below_min && !above_max;
				stop = take;
			end
		endcase
		take = take && cnt_reg >= `EIT_MIN_SAMPLES;
	end
	assign run_next = start || (run_reg && !stop);

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pri_prev_reg <= 1'b0;
			sec_prev_reg <= 1'b0;
			run_reg <= 1'b0;
			cnt_reg <= `EIT_WORD_RESET;
			meas_evt_reg <= 1'b0;
			meas_cnt_reg <= `EIT_WORD_RESET;
			last_int_reg <= `EIT_WORD_RESET;
		end else begin
			pri_prev_reg <= pri_truth;
			sec_prev_reg <= sec_truth;
			meas_evt_reg <= take;
			if (take) begin
				meas_cnt_reg <= take_val;
				last_int_reg <= take_val;
			end
			if (active) begin
				run_reg <= run_next;
				if (start) begin
					cnt_reg <= 32'h0000_0001;
				end else if (run_reg && cnt_reg != 32'hffff_ffff) begin
					cnt_reg <= cnt_reg + 32'h0000_0001;
				end
			end
		end
	end

	// time unit conversion, q16.16 result
	logic [47:0] unit_scale;
	logic [31:0] conv_in, conv_val;
	logic [79:0] conv_prod;
	assign unit_scale = unit == 2'd0 ? SC_SAMPLE[47:0] :
		unit == 2'd1 ? SC_US[47:0] :
		unit == 2'd2 ? SC_MS[47:0] : SC_S[47:0];
	assign conv_in = meas_evt_reg ? meas_cnt_reg : live_cnt;
	assign conv_prod = {48'h0, conv_in} * {32'h0, unit_scale};
	assign conv_val = conv_prod[79:48] != 32'h0000_0000 ? 32'hffff_ffff :
		conv_prod[47:16];

	// sequential divider for frequency
	logic [47:0] freq_num;
	logic [32:0] rem_try;
	logic rem_ge, meas_div, live_div;
	logic [31:0] quot_sat;
	assign freq_num = unit == 2'd1 ? F_KHZ[47:0] :
		unit == 2'd2 ? F_BPM[47:0] : F_HZ[47:0];
	assign meas_div = meas_evt_reg && is_freq;
	assign live_div = out_mode == event_interval_timer_pkg::OUT_LIVE &&
		is_freq && run_reg && !div_busy_reg && !div_done_reg &&
		!meas_evt_reg && last_int_reg != 32'h0000_0000 &&
		cnt_reg > last_int_reg;
	assign rem_try = {div_rem_reg, div_num_reg[47]};
	assign rem_ge = rem_try >= {1'b0, div_den_reg};
	assign quot_sat = div_q_reg[47:32] != 16'h0000 ? 32'hffff_ffff :
		div_q_reg[31:0];

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			div_busy_reg <= 1'b0;
			div_done_reg <= 1'b0;
			div_meas_reg <= 1'b0;
			div_bit_reg <= 6'h00;
			div_num_reg <= 48'h0;
			div_q_reg <= 48'h0;
			div_rem_reg <= 32'h0;
			div_den_reg <= 32'h0;
		end else begin
			div_done_reg <= 1'b0;
			if (meas_div || live_div) begin
				div_busy_reg <= 1'b1;
				div_meas_reg <= meas_div;
				div_bit_reg <= 6'h2f;
				div_num_reg <= freq_num;
				div_q_reg <= 48'h0;
				div_rem_reg <= 32'h0;
				div_den_reg <= meas_div ? meas_cnt_reg : live_cnt;
			end else if (div_busy_reg) begin
				div_rem_reg <= rem_ge ? 32'(rem_try - {1'b0, div_den_reg}) :
					rem_try[31:0];
				div_q_reg <= {div_q_reg[46:0], rem_ge};
				div_num_reg <= {div_num_reg[46:0], 1'b0};
				div_bit_reg <= div_bit_reg - 6'h01;
				if (div_bit_reg == 6'h00) begin
					div_busy_reg <= 1'b0;
					div_done_reg <= 1'b1;
				end
			end
		end
	end

	// output stage
	logic out_load, live_load, hot, time_live;
	logic [31:0] out_val, live_val, smooth_val, result_next;
	logic signed [32:0] smooth_diff;
	assign hot = out_mode == event_interval_timer_pkg::OUT_LIVE;
	assign out_load = (meas_evt_reg && !is_freq) ||
		(div_done_reg && div_meas_reg);
	assign out_val = is_freq ? quot_sat : conv_val;
	assign time_live = !is_freq && !meas_evt_reg && run_reg;
	assign live_load = hot && (time_live ||
		(is_freq && div_done_reg && !div_meas_reg));
	assign live_val = out_val;
	assign smooth_diff = $signed({1'b0, out_val}) - $signed({1'b0, o_result});
	assign smooth_val = 32'($signed({1'b0, o_result}) +
		(smooth_diff >>> tau));
	assign result_next = out_load ?
		(out_mode == event_interval_timer_pkg::OUT_SMOOTH ? smooth_val :
		out_val) : live_load ? live_val : o_result;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_result <= `EIT_WORD_RESET;
			o_valid <= 1'b0;
			meas_total_reg <= `EIT_WORD_RESET;
		end else begin
			o_result <= result_next;
			o_valid <= out_load;
			if (out_load) begin
				meas_total_reg <= meas_total_reg + 32'h0000_0001;
			end
		end
	end

	// apb register file
	logic setup, wr_en, hit;
	logic [7:0] a;
	logic [31:0] rd_data, status;
	assign setup = i_psel && !i_penable;
	assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
	assign a = {i_paddr[7:2], 2'b00};
	assign status = {27'h0, div_busy_reg, active, sec_truth, pri_truth,
		run_reg};
	assign hit = i_paddr[1:0] == 2'b00 && a <= `EIT_OFS_MEAS_COUNT &&
		i_paddr[ADDR_W-1:2] == (ADDR_W-2)'(a[7:2]);
	assign rd_data =
		a == `EIT_OFS_CTRL ? {17'h0, ctrl_reg} :
		a == `EIT_OFS_PRI_CFG ? {29'h0, pri_cfg_reg} :
		a == `EIT_OFS_PRI_SCALE ? pri_scale_reg :
		a == `EIT_OFS_PRI_LOWER ? pri_lo_reg :
		a == `EIT_OFS_PRI_UPPER ? pri_hi_reg :
		a == `EIT_OFS_SEC_CFG ? {29'h0, sec_cfg_reg} :
		a == `EIT_OFS_SEC_SCALE ? sec_scale_reg :
		a == `EIT_OFS_SEC_LOWER ? sec_lo_reg :
		a == `EIT_OFS_SEC_UPPER ? sec_hi_reg :
		a == `EIT_OFS_BOUND_MIN ? bmin_reg :
		a == `EIT_OFS_BOUND_MAX ? bmax_reg :
		a == `EIT_OFS_RESULT ? o_result :
		a == `EIT_OFS_STATUS ? status :
		a == `EIT_OFS_MEAS_COUNT ? meas_total_reg : 32'h0000_0000;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= `EIT_WORD_RESET;
		end else begin
			o_pready <= setup;
			o_pslverr <= setup && !hit;
			o_prdata <= (setup && hit && !i_pwrite) ? rd_data :
				32'h0000_0000;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ctrl_reg <= `EIT_CTRL_RESET;
			pri_cfg_reg <= `EIT_CFG_RESET;
			sec_cfg_reg <= `EIT_CFG_RESET;
			pri_scale_reg <= `EIT_SCALE_RESET;
			sec_scale_reg <= `EIT_SCALE_RESET;
			pri_lo_reg <= `EIT_WORD_RESET;
			pri_hi_reg <= `EIT_WORD_RESET;
			sec_lo_reg <= `EIT_WORD_RESET;
			sec_hi_reg <= `EIT_WORD_RESET;
			bmin_reg <= `EIT_WORD_RESET;
			bmax_reg <= `EIT_WORD_RESET;
		end else if (wr_en && !o_pslverr) begin
			unique case (a)
				`EIT_OFS_CTRL: ctrl_reg <= i_pwdata[`EIT_CTRL_WIDTH-1:0];
				`EIT_OFS_PRI_CFG: pri_cfg_reg <= i_pwdata[2:0];
				`EIT_OFS_PRI_SCALE: pri_scale_reg <= i_pwdata;
				`EIT_OFS_PRI_LOWER: pri_lo_reg <= i_pwdata;
				`EIT_OFS_PRI_UPPER: pri_hi_reg <= i_pwdata;
				`EIT_OFS_SEC_CFG: sec_cfg_reg <= i_pwdata[2:0];
				`EIT_OFS_SEC_SCALE: sec_scale_reg <= i_pwdata;
				`EIT_OFS_SEC_LOWER: sec_lo_reg <= i_pwdata;
				`EIT_OFS_SEC_UPPER: sec_hi_reg <= i_pwdata;
				`EIT_OFS_BOUND_MIN: bmin_reg <= i_pwdata;
				`EIT_OFS_BOUND_MAX: bmax_reg <= i_pwdata;
				default: ;
			endcase
		end
	end

	// checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	sequence s_take;
		take && !is_freq;
	endsequence
	sequence s_loaded;
		##2 o_valid;
	endsequence

	a_valid_single_pulse: assert property (o_valid |=> !o_valid)
		else $error("valid held longer than one cycle");
	a_take_to_valid: assert property (s_take |-> s_loaded)
		else $error("time measurement did not raise valid two cycles on");
	a_min_two_samples: assert property (meas_evt_reg |->
		meas_cnt_reg >= 32'h0000_0002)
		else $error("measurement shorter than two samples");
	a_clamp_max: assert property (meas_evt_reg && bounded &&
		bmax_reg != 32'h0000_0000 |-> meas_cnt_reg <= bmax_reg)
		else $error("measurement above maximum bound");
	a_duration_drop: assert property (mode ==
		event_interval_timer_pkg::MEAS_DURATION && pri_off && run_reg &&
		bounded && above_max && !meas_div |=> !meas_evt_reg ##1 !o_valid)
		else $error("out of bound duration produced a measurement");
	a_between_no_retrig: assert property (mode ==
		event_interval_timer_pkg::MEAS_BETWEEN && active && pri_on &&
		run_reg && bounded && below_min && cnt_reg != 32'hffff_ffff
		|=> cnt_reg == $past(cnt_reg) + 32'h0000_0001)
		else $error("primary onset restarted timer below minimum");
	a_sec_window: assert property (mode ==
		event_interval_timer_pkg::MEAS_BETWEEN && sec_on && bounded &&
		below_min |=> !meas_evt_reg)
		else $error("secondary onset accepted before minimum");
	a_latch_hold: assert property (out_mode ==
		event_interval_timer_pkg::OUT_LATCH && !out_load |=>
		$stable(o_result))
		else $error("latched result changed without a measurement");
	a_gate_freeze: assert property (!active |=> $stable(cnt_reg) &&
		$stable(run_reg))
		else $error("timer advanced while gated off");
	a_onset_restart: assert property (active && start |=>
		cnt_reg == 32'h0000_0001 && run_reg)
		else $error("onset did not restart the counter");
	a_apb_answer: assert property (setup |=> o_pready ##1 !o_pready)
		else $error("apb answer not one cycle after setup");
endmodule // event_interval_timer

// *** tb/sample_source.sv ***
// upstream model driving the primary and secondary sample streams
`timescale 1ns/1ps
module sample_source (
	// clock
	input wire logic i_clk_sys,
	// streams
	output logic [31:0] o_pri_sample,
	output logic o_pri_logic,
	output logic [31:0] o_sec_sample,
	output logic o_sec_logic
);
	initial begin
		o_pri_sample = 32'h0000_0032;
		o_pri_logic = 1'b0;
		o_sec_sample = 32'h0000_0032;
		o_sec_logic = 1'b0;
	end
	// high level is logic true and a sample of 0x96, low is 0x32
	task automatic pri_set(input logic v);
		o_pri_logic <= v;
		o_pri_sample <= v ? 32'h0000_0096 : 32'h0000_0032;
	endtask
	// n pulses, onset every per cycles, each wid cycles high
	task automatic train(input int n, input int per, input int wid);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk_sys);
			pri_set(1'b1);
			repeat (wid) @(posedge i_clk_sys);
			pri_set(1'b0);
			repeat (per - wid - 1) @(posedge i_clk_sys);
		end
	endtask
	// one-cycle secondary true pulse
	task automatic sec_pulse();
		@(posedge i_clk_sys);
		o_sec_logic <= 1'b1;
		o_sec_sample <= 32'h0000_0096;
		@(posedge i_clk_sys);
		o_sec_logic <= 1'b0;
		o_sec_sample <= 32'h0000_0032;
	endtask
	// primary onset, secondary onset gap cycles later
	task automatic pair(input int gap);
		@(posedge i_clk_sys);
		pri_set(1'b1);
		repeat (gap) @(posedge i_clk_sys);
		pri_set(1'b0);
		o_sec_logic <= 1'b1;
		o_sec_sample <= 32'h0000_0096;
		@(posedge i_clk_sys);
		o_sec_logic <= 1'b0;
		o_sec_sample <= 32'h0000_0032;
		repeat (20) @(posedge i_clk_sys);
	endtask
endmodule // sample_source

// *** tb/event_interval_timer_bench.sv ***
// self-checking bench for the event interval timer
`timescale 1ns/1ps
`include "event_interval_timer_map.svh"
module event_interval_timer_bench;
	logic i_clk_sys, i_rst, i_psel, i_penable, i_pwrite, i_gate_enable;
	logic [7:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, o_result, pri_s, sec_s, rd, last_res;
	logic o_pready, o_pslverr, o_valid, pri_l, sec_l, er, prev_v;
	int err_total = 0, checks = 0, nvalid = 0, n0 = 0, dbl = 0;
	event_interval_timer #(.CLK_HZ(50000000), .ADDR_W(8)) u_dut (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_pri_sample(pri_s), .i_pri_logic(pri_l),
		.i_sec_sample(sec_s), .i_sec_logic(sec_l),
		.i_gate_enable(i_gate_enable), .o_result(o_result),
		.o_valid(o_valid));
	sample_source u_src (.i_clk_sys(i_clk_sys), .o_pri_sample(pri_s),
		.o_pri_logic(pri_l), .o_sec_sample(sec_s), .o_sec_logic(sec_l));
	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	always @(negedge i_clk_sys) begin
		if (o_valid === 1'b1) begin
			nvalid++;
			last_res = o_result;
			if (prev_v) dbl++;
		end
		prev_v = (o_valid === 1'b1);
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic cmp32(input logic [31:0] got, exp, input string msg);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge i_clk_sys);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk_sys);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clk_sys);
		end while (o_pready !== 1'b1);
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	function automatic logic [31:0] cw(input logic [1:0] m, u, o,
		input logic b, input logic [1:0] g, input logic man);
		return {22'h0, man, g, b, o, u, m};
	endfunction
	// counts measurements since mark and checks the latched result
	task automatic measure(input string name, input int expn,
		input logic [31:0] expr);
		repeat (12) @(posedge i_clk_sys);
		cmp32(32'(nvalid - n0), 32'(expn), "valid count");
		if (expn > 0) cmp32(last_res, expr, "result");
		$display("test %s done", name);
		n0 = nvalid;
	endtask
	initial begin
		i_rst = 1'b1;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0000_0000;
		i_gate_enable = 1'b0;
		repeat (6) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		apb(1'b0, `EIT_OFS_CTRL, 32'h0);
		cmp32(rd, 32'h0000_0000, "ctrl reset");
		apb(1'b0, `EIT_OFS_PRI_SCALE, 32'h0);
		cmp32(rd, 32'h0001_0000, "scale reset");
		apb(1'b1, `EIT_OFS_PRI_LOWER, 32'h0000_0064);
		apb(1'b0, `EIT_OFS_PRI_LOWER, 32'h0);
		cmp32(rd, 32'h0000_0064, "lower readback");
		apb(1'b0, 8'h38, 32'h0);
		cmp32({31'h0, er}, 32'h1, "unmapped slverr");
		$display("test registers done");
		n0 = nvalid;
		u_src.train(4, 10, 3);
		measure("period", 3, 32'h000a_0000);
		apb(1'b1, `EIT_OFS_PRI_CFG, 32'h2);
		apb(1'b1, `EIT_OFS_PRI_UPPER, 32'h0000_0010);
		u_src.train(3, 12, 4);
		measure("above", 3, 32'h000c_0000);
		apb(1'b1, `EIT_OFS_PRI_CFG, 32'h4);
		apb(1'b1, `EIT_OFS_PRI_UPPER, 32'h0000_00c8);
		u_src.train(3, 14, 4);
		measure("inside", 3, 32'h000e_0000);
		apb(1'b1, `EIT_OFS_PRI_CFG, 32'h0);
		apb(1'b1, `EIT_OFS_BOUND_MAX, 32'h6);
		apb(1'b1, `EIT_OFS_CTRL, cw(2'd0, 2'd0, 2'd0, 1'b1, 2'd0, 1'b0));
		u_src.train(3, 10, 3);
		measure("clamp", 3, 32'h0006_0000);
		apb(1'b1, `EIT_OFS_CTRL, cw(2'd1, 2'd1, 2'd0, 1'b0, 2'd0, 1'b0));
		u_src.train(3, 10, 3);
		repeat (70) @(posedge i_clk_sys);
		cmp32(last_res, 32'h1388_0000, "frequency khz");
		$display("test frequency done");
		n0 = nvalid;
		apb(1'b1, `EIT_OFS_BOUND_MIN, 32'h5);
		apb(1'b1, `EIT_OFS_BOUND_MAX, 32'h0);
		apb(1'b1, `EIT_OFS_CTRL, cw(2'd2, 2'd0, 2'd0, 1'b1, 2'd0, 1'b0));
		u_src.train(2, 20, 4);
		measure("short duration", 0, 32'h0);
		u_src.train(2, 20, 8);
		measure("duration", 2, 32'h0008_0000);
		apb(1'b1, `EIT_OFS_BOUND_MIN, 32'h0);
		apb(1'b1, `EIT_OFS_CTRL, cw(2'd0, 2'd0, 2'd0, 1'b0, 2'd2, 1'b0));
		u_src.train(3, 10, 3);
		measure("manual off", 0, 32'h0);
		i_gate_enable <= 1'b1;
		apb(1'b1, `EIT_OFS_CTRL, cw(2'd0, 2'd0, 2'd0, 1'b0, 2'd1, 1'b0));
		u_src.train(3, 10, 3);
		measure("gate input", 2, 32'h000a_0000);
		apb(1'b1, `EIT_OFS_SEC_CFG, 32'h0);
		apb(1'b1, `EIT_OFS_CTRL, cw(2'd3, 2'd0, 2'd0, 1'b0, 2'd0, 1'b0));
		u_src.pair(7);
		u_src.pair(7);
		measure("between", 2, 32'h0007_0000);
		apb(1'b1, `EIT_OFS_BOUND_MIN, 32'h5);
		apb(1'b1, `EIT_OFS_CTRL, cw(2'd3, 2'd0, 2'd0, 1'b1, 2'd0, 1'b0));
		u_src.pair(3);
		measure("early secondary", 0, 32'h0);
		u_src.train(2, 4, 1);
		u_src.sec_pulse();
		measure("no retrigger", 1, 32'h0008_0000);
		apb(1'b1, `EIT_OFS_CTRL, cw(2'd3, 2'd0, 2'd2, 1'b0, 2'd0, 1'b0));
		u_src.pair(7);
		measure("live between", 1, 32'h0007_0000);
		cmp32(o_result, 32'h0007_0000, "live hold");
		apb(1'b1, `EIT_OFS_CTRL, cw(2'd0, 2'd0, 2'd1, 1'b0, 2'd0, 1'b0) |
			(32'h0000_0001 << `EIT_CTRL_TAU_LSB));
		u_src.train(3, 10, 3);
		measure("smooth", 2, 32'h0009_4000);
		cmp32(32'(dbl), 32'h0, "valid wider than one cycle");
		final_report();
	end
	initial begin
		#400000;
		err_total++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end
endmodule // event_interval_timer_bench
